// file: rtl/pulse_test_sequencer.sv
// periodic light/dark switching test of the output switches
`timescale 1ns/100ps
`default_nettype none
module pulse_test_sequencer #(
   parameter int INTERVAL_CYCLES = safe_diag_pkg::TEST_INTERVAL_CYCLES,
   parameter int PULSE_CYCLES = safe_diag_pkg::TEST_PULSE_CYCLES
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rstn,
   // switch state
   input wire logic en,
   input wire safe_diag_pkg::slot_vec_t nominal,
   input wire safe_diag_pkg::slot_vec_t readback,
   // test drive and result
   output safe_diag_pkg::slot_vec_t invert_mask,
   output logic fail_light,
   output logic fail_dark,
   output logic [2:0] fail_slot
);
   import safe_diag_pkg::*;

   localparam int GW = $clog2(INTERVAL_CYCLES + 1);
   localparam int PW = $clog2(PULSE_CYCLES + 1);

   typedef enum logic [0:0] {T_WAIT = 1'b0, T_PULSE = 1'b1} test_state_t;

   test_state_t state;
   logic [GW-1:0] gap;
   logic [PW-1:0] width;
   logic [2:0] slot;
   logic light;
   logic [2:0] next_slot;

   assign next_slot = (slot == 3'(NUM_SLOTS - 1)) ? 3'h0 : 3'(slot + 3'h1);

   // interval between tests, held reloaded while disabled
   always_ff @(posedge ref_clk) begin
      if (!rstn || !en || gap == '0) begin
         gap <= GW'(INTERVAL_CYCLES - 1);
      end else begin
         gap <= gap - 1'b1;
      end
   end

   // pulse one switch to the opposite state, then judge its readback
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         state <= T_WAIT;
         width <= '0;
         slot <= '0;
         light <= 1'b0;
         invert_mask <= '0;
         fail_light <= 1'b0;
         fail_dark <= 1'b0;
         fail_slot <= '0;
      end else begin
         fail_light <= 1'b0;
         fail_dark <= 1'b0;
         unique case (state)
            T_WAIT: begin
               invert_mask <= '0;
               if (en && gap == '0) begin
                  if (!nominal[slot] && slot == 3'(SLOT_COMMON_LS)) begin
                     slot <= next_slot; // common low side has no light test
                  end else begin
                     state <= T_PULSE;
                     light <= !nominal[slot];
                     invert_mask <= slot_vec_t'(6'h01 << slot);
                     width <= PW'(PULSE_CYCLES - 1);
                  end
               end
            end
            T_PULSE: begin
               if (!en || nominal[slot] == light) begin
                  state <= T_WAIT; // shutdown or a changed command aborts the pulse
                  invert_mask <= '0;
               end else if (width != '0) begin
                  width <= width - 1'b1;
               end else begin
                  state <= T_WAIT;
                  invert_mask <= '0;
                  slot <= next_slot;
                  fail_slot <= slot;
                  fail_light <= light && !readback[slot];
                  fail_dark <= !light && readback[slot];
               end
            end
         endcase
      end
   end

endmodule // pulse_test_sequencer
`default_nettype wire

// file: rtl/safe_diag_pkg.sv
// shared constants, types and code helpers for the safe output diagnostics
package safe_diag_pkg;

   // switch slots: main high side, zones one to three, main low side, common low side
   localparam int NUM_SLOTS = 6;
   localparam int NUM_GROUPS = 5;
   localparam int NUM_ENTRIES = NUM_SLOTS * NUM_GROUPS;
   localparam int SLOT_MAIN_LS = 4;
   localparam int SLOT_COMMON_LS = 5;

   typedef logic [NUM_SLOTS-1:0] slot_vec_t;
   typedef logic [NUM_ENTRIES-1:0] fault_vec_t;

   // sixteen bit diagnostic code: class byte, fault group, affected output
   typedef struct packed {
      logic [7:0] cls;
      logic [3:0] grp;
      logic [3:0] idx;
   } diag_code_t;

   localparam logic [7:0] CODE_CLASS = 8'h02;

   // fault groups in latch order
   localparam int G_RB_ZONE = 0;
   localparam int G_SHORT = 1;
   localparam int G_LIGHT = 2;
   localparam int G_DARK = 3;
   localparam int G_RB_SW = 4;

   localparam logic [3:0] GRP_NIB [NUM_GROUPS] = '{4'h1, 4'h3, 4'h5, 4'h6, 4'h8};
   localparam logic [3:0] SLOT_IDX [NUM_SLOTS] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h8, 4'h9};
   // which slots each group can report
   localparam slot_vec_t GRP_MASK [NUM_GROUPS] = '{6'h0e, 6'h0f, 6'h1f, 6'h3f, 6'h31};
   // every group except short/overload shuts all outputs down
   localparam fault_vec_t GLOBAL_MASK = 30'h3ffff03f;
   localparam fault_vec_t FAULT_RESET = 30'h00000000;

   // timing
   localparam int CLK_PERIOD_PS = 8000;
   localparam int TEST_PULSE_NS = 800;
   localparam int TEST_PULSE_CYCLES = (TEST_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int SETTLE_NS = 400;
   localparam int SETTLE_CYCLES = (SETTLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int TEST_INTERVAL_US = 1000;
   localparam int TEST_INTERVAL_CYCLES = TEST_INTERVAL_US * 1000000 / CLK_PERIOD_PS;

   // code of one latch entry
   function automatic diag_code_t code_of(input int e);
      diag_code_t c;
      c.cls = CODE_CLASS;
      c.grp = GRP_NIB[e / NUM_SLOTS];
      c.idx = SLOT_IDX[e % NUM_SLOTS];
      return c;
   endfunction

endpackage

// file: rtl/safe_output_diag_codes.sv
// fault latching, safe-state reaction, indicators and code reporting for safe outputs
`timescale 1ns/100ps
`default_nettype none
module safe_output_diag_codes #(
   parameter int TEST_INTERVAL_CYCLES = safe_diag_pkg::TEST_INTERVAL_CYCLES,
   parameter int TEST_PULSE_CYCLES = safe_diag_pkg::TEST_PULSE_CYCLES
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rstn,
   // requested outputs: main, zone one, zone two, zone three
   input wire logic [3:0] output_cmd,
   // switch drive and readback, one bit per slot
   output safe_diag_pkg::slot_vec_t switch_drive,
   input wire safe_diag_pkg::slot_vec_t readback,
   // current sensing per output
   input wire logic [3:0] overload_detect,
   // diagnostic report
   output logic diag_valid,
   output safe_diag_pkg::diag_code_t diag_code,
   input wire logic diag_ready,
   // acknowledgement from the controller
   input wire logic ack_valid,
   input wire safe_diag_pkg::diag_code_t ack_code,
   // indicators
   output logic [3:0] red_led,
   output logic safe_state
);
   import safe_diag_pkg::*;

   localparam int SW = $clog2(SETTLE_CYCLES + 1);

   fault_vec_t fault;
   fault_vec_t set;
   fault_vec_t clr;
   slot_vec_t nominal;
   slot_vec_t next_drive;
   slot_vec_t invert_mask;
   slot_vec_t overload6;
   logic global_any;
   logic check_ok;
   logic [SW-1:0] settle;
   logic fail_light;
   logic fail_dark;
   logic [2:0] fail_slot;
   logic [4:0] ptr;

   assign global_any = |(fault & GLOBAL_MASK);
   assign overload6 = {2'b00, overload_detect};

   // wanted switch state before tests; a shorted output stays off alone
   always_comb begin
      nominal[3:0] = output_cmd & ~fault[G_SHORT*NUM_SLOTS +: 4];
      nominal[SLOT_MAIN_LS] = output_cmd[0];
      nominal[SLOT_COMMON_LS] = |output_cmd[3:1];
      next_drive = global_any ? slot_vec_t'(0) : (nominal ^ invert_mask);
   end

   // registered switch drive
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         switch_drive <= '0;
      end else begin
         switch_drive <= next_drive;
      end
   end

   // readback checks wait until the drive has been steady
   always_ff @(posedge ref_clk) begin
      if (!rstn || next_drive != switch_drive) begin
         settle <= SW'(SETTLE_CYCLES);
      end else if (settle != '0) begin
         settle <= settle - 1'b1;
      end
   end
   assign check_ok = (settle == '0);

   pulse_test_sequencer #(
      .INTERVAL_CYCLES(TEST_INTERVAL_CYCLES),
      .PULSE_CYCLES(TEST_PULSE_CYCLES)
   ) u_tester (
      .ref_clk(ref_clk),
      .rstn(rstn),
      .en(!global_any),
      .nominal(nominal),
      .readback(readback),
      .invert_mask(invert_mask),
      .fail_light(fail_light),
      .fail_dark(fail_dark),
      .fail_slot(fail_slot)
   );

   // fault detection into latch entries
   always_comb begin
      set = '0;
      for (int s = 0; s < NUM_SLOTS; s++) begin
         set[G_RB_ZONE*NUM_SLOTS+s] = GRP_MASK[G_RB_ZONE][s] && check_ok
                                      && readback[s] && !switch_drive[s];
         set[G_SHORT*NUM_SLOTS+s] = GRP_MASK[G_SHORT][s] && overload6[s];
         set[G_LIGHT*NUM_SLOTS+s] = GRP_MASK[G_LIGHT][s] && fail_light && fail_slot == 3'(s);
         set[G_DARK*NUM_SLOTS+s] = fail_dark && fail_slot == 3'(s);
         set[G_RB_SW*NUM_SLOTS+s] = GRP_MASK[G_RB_SW][s] && check_ok
                                    && readback[s] != switch_drive[s];
      end
   end

   // acknowledgement clears only the matching latched code
   always_comb begin
      clr = '0;
      for (int e = 0; e < NUM_ENTRIES; e++) begin
         clr[e] = ack_valid && ack_code == code_of(e);
      end
   end

   // fault latches, a new event wins over its clear
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         fault <= FAULT_RESET;
      end else begin
         fault <= (fault & ~clr) | set;
      end
   end

   // indicators and safe-state flag
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         red_led <= '0;
         safe_state <= 1'b0;
      end else begin
         red_led <= global_any ? 4'hf : fault[G_SHORT*NUM_SLOTS +: 4];
         safe_state <= global_any;
      end
   end

   // round-robin report of every latched code
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         ptr <= '0;
         diag_valid <= 1'b0;
         diag_code <= '0;
      end else if (!diag_valid || diag_ready) begin
         diag_valid <= fault[ptr];
         diag_code <= code_of(int'(ptr));
         ptr <= (ptr == 5'(NUM_ENTRIES - 1)) ? 5'h00 : 5'(ptr + 5'h01);
      end
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rstn);

   property p_zone_idx;
      diag_valid && diag_code.grp == 4'h1 |-> diag_code.idx inside {4'h1, 4'h2, 4'h3};
   endproperty
   a_zone_idx: assert property (p_zone_idx) else $error("zone readback code has bad index");

   property p_code_form;
      diag_valid |-> diag_code.cls == 8'h02 && diag_code.idx inside {4'h0, 4'h1, 4'h2, 4'h3, 4'h8, 4'h9};
   endproperty
   a_code_form: assert property (p_code_form) else $error("diagnostic code malformed");

   property p_zone_shutdown;
      |fault[3:1] |=> switch_drive == 6'h00;
   endproperty
   a_zone_shutdown: assert property (p_zone_shutdown) else $error("zone fault left outputs on");

   property p_short_local;
      overload_detect[2] |-> ##2 (red_led[2] && !switch_drive[2]);
   endproperty
   a_short_local: assert property (p_short_local) else $error("overload did not isolate output");

   property p_light_fail;
      fail_light |-> ##2 (switch_drive == 6'h00 && safe_state);
   endproperty
   a_light_fail: assert property (p_light_fail) else $error("light test failure not shut down");

   property p_dark_fail;
      fail_dark |-> ##2 (switch_drive == 6'h00 && red_led == 4'hf);
   endproperty
   a_dark_fail: assert property (p_dark_fail) else $error("dark test failure not shut down");

   property p_switch_mismatch;
      check_ok && readback[SLOT_MAIN_LS] != switch_drive[SLOT_MAIN_LS] |=> fault[28] ##1 safe_state;
   endproperty
   a_switch_mismatch: assert property (p_switch_mismatch) else $error("low side mismatch not latched");

   property p_restart;
      global_any && ((fault & ~clr) & GLOBAL_MASK) == '0 && set == '0 |=> !global_any ##1 !safe_state;
   endproperty
   a_restart: assert property (p_restart) else $error("ack did not restart outputs");

   property p_leds;
      global_any |=> red_led == 4'hf;
   endproperty
   a_leds: assert property (p_leds) else $error("red LEDs not lit on shutdown");

   property p_stray_ack;
      ack_valid && (clr & fault) == '0 |=> fault == ($past(fault) | $past(set));
   endproperty
   a_stray_ack: assert property (p_stray_ack) else $error("stray ack changed latches");

   property p_report_hold;
      diag_valid && !diag_ready |=> diag_valid && $stable(diag_code);
   endproperty
   a_report_hold: assert property (p_report_hold) else $error("offered code dropped before taken");

   c_zone_fault: cover property (|fault[3:1]);
   c_short_ack: cover property (fault[G_SHORT*NUM_SLOTS+1] ##[1:50] !fault[G_SHORT*NUM_SLOTS+1]);
   c_dark_fail: cover property (fail_dark);
   c_report: cover property (diag_valid && diag_ready);

endmodule // safe_output_diag_codes
`default_nettype wire

// file: sim/diag_ack_partner.sv
// remote controller model: takes diagnostic codes and sends acknowledgements
`timescale 1ns/100ps
`default_nettype none
module diag_ack_partner (
   // clock
   input wire logic ref_clk,
   // report side
   input wire logic slow,
   output logic diag_ready,
   // acknowledgement side
   output logic ack_valid,
   output safe_diag_pkg::diag_code_t ack_code
);
   import safe_diag_pkg::*;
   // idle at time zero
   initial begin
      diag_ready = 1'b0;
      ack_valid = 1'b0;
      ack_code = 16'h0000;
   end
   // ready held high, or stalling every other cycle when slow
   always @(negedge ref_clk) begin
      diag_ready <= slow ? ~diag_ready : 1'b1;
   end
   // one-cycle ack, sent only after the cause is gone
   task automatic send_ack(input diag_code_t c);
      @(negedge ref_clk);
      ack_valid <= 1'b1;
      ack_code <= c;
      @(negedge ref_clk);
      ack_valid <= 1'b0;
      ack_code <= ~c; // released bus shows no stale code
   endtask
endmodule // diag_ack_partner
`default_nettype wire

// file: sim/safe_output_diag_codes_tb.sv
// self-checking bench for the safe output diagnostic codes
`timescale 1ns/100ps
`default_nettype none
module safe_output_diag_codes_tb;
   import safe_diag_pkg::*;
   logic ref_clk = 1'b0;
   logic rstn = 1'b0;
   logic slow = 1'b0;
   logic [3:0] output_cmd = 4'h0;
   logic [3:0] overload_detect = 4'h0;
   slot_vec_t readback = 6'h00;
   slot_vec_t stuck_on = 6'h00;
   slot_vec_t stuck_off = 6'h00;
   slot_vec_t switch_drive;
   logic diag_valid, diag_ready, ack_valid, safe_state;
   diag_code_t diag_code, ack_code;
   logic [3:0] red_led;
   int fails = 0;
   int num_checks = 0;
   int cycles = 0;

   // clock
   always #4 ref_clk = ~ref_clk;

   safe_output_diag_codes #(.TEST_INTERVAL_CYCLES(200), .TEST_PULSE_CYCLES(4)) i_dut (
      .ref_clk(ref_clk), .rstn(rstn), .output_cmd(output_cmd), .switch_drive(switch_drive),
      .readback(readback), .overload_detect(overload_detect), .diag_valid(diag_valid),
      .diag_code(diag_code), .diag_ready(diag_ready), .ack_valid(ack_valid), .ack_code(ack_code),
      .red_led(red_led), .safe_state(safe_state));

   diag_ack_partner i_partner (
      .ref_clk(ref_clk), .slow(slow), .diag_ready(diag_ready), .ack_valid(ack_valid), .ack_code(ack_code));

   // plant: readback follows drive except injected stuck switches
   always @(negedge ref_clk) begin
      readback <= (switch_drive | stuck_on) & ~stuck_off;
   end

   // hang guard
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 20000) begin
         fails++;
         final_report();
      end
   end

   task automatic cyc(input int n);
      repeat (n) @(negedge ref_clk);
   endtask

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fails++;
         $display("[FAIL] %0t ns: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // wait for a code to be handed over, bounded
   task automatic wait_code(input logic [15:0] exp, input int limit);
      logic hit;
      hit = 1'b0;
      for (int n = 0; n < limit && !hit; n++) begin
         @(posedge ref_clk);
         hit = (diag_valid === 1'b1) && (diag_ready === 1'b1) && (diag_code === exp);
      end
      check({15'h0000, hit}, 16'h0001);
      cyc(3);
   endtask

   // overload per output, stray ack, own recovery
   task automatic t_overload;
      logic [15:0] c;
      slow = 1'b1;
      output_cmd = 4'hf;
      for (int i = 0; i < 4; i++) begin
         c = {8'h02, 4'h3, i[3:0]};
         overload_detect[i] = 1'b1;
         cyc(1);
         overload_detect = 4'h0;
         wait_code(c, 300);
         check({12'h000, red_led}, 16'h0001 << i);
         check({15'h0000, safe_state}, 16'h0000);
         i_partner.send_ack(16'h0239);
         cyc(2);
         check({12'h000, red_led}, 16'h0001 << i);
         i_partner.send_ack(c);
         cyc(3);
         check({12'h000, red_led}, 16'h0000);
      end
      slow = 1'b0;
   endtask

   // shutdown fault: all off, all red, restart on ack
   task automatic t_shut(input logic [3:0] cmd, input slot_vec_t son, input slot_vec_t soff,
                         input logic [15:0] c, input int limit);
      output_cmd = cmd;
      cyc(60);
      stuck_on = son;
      stuck_off = soff;
      wait_code(c, limit);
      check({15'h0000, safe_state}, 16'h0001);
      check({12'h000, red_led}, 16'h000f);
      check({10'h000, switch_drive}, 16'h0000);
      stuck_on = 6'h00;
      stuck_off = 6'h00;
      cyc(5);
      i_partner.send_ack(c);
      cyc(3);
      check({15'h0000, safe_state}, 16'h0000);
      check({12'h000, red_led}, 16'h0000);
   endtask

   // two shutdown faults: restart only after both are acked
   task automatic t_two;
      output_cmd = 4'h3;
      cyc(60);
      stuck_on = 6'h0c;
      wait_code(16'h0212, 300);
      wait_code(16'h0213, 300);
      stuck_on = 6'h00;
      i_partner.send_ack(16'h0212);
      cyc(3);
      check({15'h0000, safe_state}, 16'h0001);
      i_partner.send_ack(16'h0213);
      cyc(3);
      check({15'h0000, safe_state}, 16'h0000);
   endtask

   task automatic final_report;
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // main sequence
   initial begin
      cyc(12);
      check({10'h000, switch_drive}, 16'h0000);
      check({12'h000, red_led}, 16'h0000);
      rstn = 1'b1;
      output_cmd = 4'hf;
      cyc(300);
      check({14'h0000, diag_valid, safe_state}, 16'h0000);
      t_overload();
      t_two();
      t_shut(4'h1, 6'h00, 6'h01, 16'h0280, 400);
      t_shut(4'h1, 6'h00, 6'h10, 16'h0288, 400);
      t_shut(4'h0, 6'h20, 6'h00, 16'h0289, 400);
      t_shut(4'hd, 6'h00, 6'h02, 16'h0251, 1600);
      t_shut(4'hf, 6'h08, 6'h00, 16'h0263, 1600);
      final_report();
   end
endmodule // safe_output_diag_codes_tb
`default_nettype wire
